// ===== rtl/hsc_top.v
// hsc_top.v: hub strap decoding, descriptor bits, port power and pull-up timing.
// assumes APB master on clk, strap and overcurrent pins synchronous to clk,
// and pad logic outside that resolves the three-signal pins to wires.
`timescale 1ns/1ps
`include "hsc_map.vh"

// Operation
// R1: low power select means bus-powered
// R2: board keeps power select static
// R3: reset or select change restarts pull-up delay
// R4: pull-up goes high after 3 ms
// R5: eeprom strap high disables eeprom clock
// R6: eeprom strap low drives eeprom clock
// R7: eeprom strap low makes shared pin data
// R8: eeprom strap high makes shared pin gang
// R9: board keeps gang select static
// R10: per-port overcurrent affects own port only
// R11: ganged mode accepts any overcurrent input
// R12: overcurrent inputs are noise filtered
// R13: third overcurrent pull-up in two-port mode
// R14: indication pin high disables its pull-down
// R15: bus-powered reports ports power-switched
// R16: bus-powered D4 follows protection pin
// R17: self-powered reports overcurrent protection
// R18: self-powered power-good time 50 or 0
// R19: port zero upstream, ports 1-3 downstream
// R20: overcurrent switches its port power off
// R21: ganged outputs switch together
// R22: straps synchronised and sampled after reset
// R23: new trigger restarts running pull-up counter
module hsc_top #(
  parameter [`HSC_PUR_CNT_W-1:0] PUR_CYCLES = `HSC_PUR_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`HSC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire power_source_select_n,
  input wire eeprom_enable_n,
  input wire three_port_n,
  input wire overcurrent_protect_ind_n,
  input wire [2:0] port_overcurrent_n,
  input wire eeprom_serial_io_in,
  output reg eeprom_serial_io_out,
  output reg eeprom_serial_io_oe,
  output reg eeprom_serial_clock_out,
  output reg eeprom_serial_clock_oe,
  output reg eeprom_pulldown_en,
  output reg ind_pulldown_en,
  output reg oc3_pullup_en,
  output reg upstream_pullup_enable,
  output reg [2:0] port_power_on_n,
  output reg [7:0] hub_characteristics,
  output reg [7:0] port_power_on_n_to_pwrgood
);

  // ----------------------------------------------------------------------------
  // strap synchronisers
  // ----------------------------------------------------------------------------
  // order: power select, eeprom enable, shared pin, indication pin, port count
  reg [4:0] strap_meta;
  reg [4:0] strap_sync;
  reg [1:0] settle_cnt;
  reg strap_valid;
  reg pss_last;

  wire [4:0] strap_raw;
  assign strap_raw = {three_port_n, overcurrent_protect_ind_n, eeprom_serial_io_in,
                      eeprom_enable_n, power_source_select_n};

  always @(posedge clk) begin
    if (!rst_n) begin
      strap_meta <= 5'h00;
      strap_sync <= 5'h00;
    end else begin
      strap_meta <= strap_raw; // R22
      strap_sync <= strap_meta; // R22
    end
  end

  // descriptor fields are built only once the synchroniser holds real pin levels
  // two flops of latency, then one edge for the flag itself
  always @(posedge clk) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
      strap_valid <= 1'b0;
    end else if (!strap_valid) begin
      settle_cnt <= settle_cnt + 1'b1;
      strap_valid <= (settle_cnt == 2'h2); // R22
    end
  end

  wire pss_n_s;
  wire ee_en_n_s;
  wire shared_s;
  wire ind_n_s;
  wire np3_n_s;
  assign pss_n_s = strap_sync[0];
  assign ee_en_n_s = strap_sync[1];
  assign shared_s = strap_sync[2];
  assign ind_n_s = strap_sync[3];
  assign np3_n_s = strap_sync[4];

  // ----------------------------------------------------------------------------
  // register file storage
  // ----------------------------------------------------------------------------
  // the eeprom protocol itself is bit-banged by software through ctrl;
  // no serial engine sits in this block
  reg [31:0] ctrl;

  wire bus_powered;
  wire ee_active;
  wire ganged;
  assign bus_powered = ~pss_n_s; // R1
  assign ee_active = ~ee_en_n_s;
  // with the eeprom in use the gang choice is loaded by software from eeprom contents
  assign ganged = ee_active ? ctrl[`HSC_CTRL_GANG_SW] : ~shared_s; // R8

  // ----------------------------------------------------------------------------
  // upstream pull-up delay
  // ----------------------------------------------------------------------------
  // the board holds the select static; a change is still honoured as a trigger
  wire pss_change;
  wire pur_done;
  assign pss_change = strap_valid && (pss_n_s != pss_last); // R3

  always @(posedge clk) begin
    if (!rst_n) begin
      pss_last <= 1'b0;
    end else begin
      pss_last <= pss_n_s;
    end
  end

  // a usb bus reset never reaches this timer; only rst_n and the select pin do
  hsc_pullup_timer #(
    .CYCLES(PUR_CYCLES)
  ) u_pullup_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(pss_change), // R23
    .done(pur_done)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      upstream_pullup_enable <= 1'b0; // R3
    end else begin
      upstream_pullup_enable <= pur_done && !pss_change; // R4
    end
  end

  // ----------------------------------------------------------------------------
  // overcurrent filtering and port power
  // ----------------------------------------------------------------------------
  wire [2:0] oc_filt_n;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_oc
      hsc_oc_filter u_oc_filter (
        .clk(clk),
        .rst_n(rst_n),
        .raw_n(port_overcurrent_n[gi]),
        .filt_n(oc_filt_n[gi]) // R12
      );
    end
  endgenerate

  // port 3 input is masked in two-port mode; the pad pull-up keeps it idle too
  wire [2:0] oc_active;
  wire any_oc;
  assign oc_active = ~oc_filt_n & {~np3_n_s, 2'h3};
  assign any_oc = |oc_active; // R11

  reg [2:0] next_power_on;
  integer pi;
  always @* begin
    next_power_on = 3'h0;
    for (pi = 0; pi < 3; pi = pi + 1) begin
      if (ganged) begin
        next_power_on[pi] = ctrl[`HSC_CTRL_PWR_REQ_LSB] && !any_oc; // R21
      end else begin
        next_power_on[pi] = ctrl[`HSC_CTRL_PWR_REQ_LSB + pi] && !oc_active[pi]; // R10
      end
    end
  end

  // downstream ports 1-3 map to bits 0-2; port zero is the upstream pair
  // power comes back by itself once the filtered fault clears
  always @(posedge clk) begin
    if (!rst_n) begin
      port_power_on_n <= 3'h7;
    end else begin
      port_power_on_n <= ~next_power_on; // R20 R19
    end
  end

  // ----------------------------------------------------------------------------
  // pad controls for eeprom and strap pins
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      eeprom_serial_clock_out <= 1'b0;
      eeprom_serial_clock_oe <= 1'b0;
      eeprom_serial_io_out <= 1'b0;
      eeprom_serial_io_oe <= 1'b0;
      eeprom_pulldown_en <= 1'b0;
    end else begin
      // clock pin stays undriven with the eeprom disabled
      eeprom_serial_clock_oe <= strap_valid && ee_active; // R5 R6
      eeprom_serial_clock_out <= ee_active && ctrl[`HSC_CTRL_EE_CLK]; // R6
      // the shared pin is only driven in eeprom mode, never when it is a strap
      eeprom_serial_io_oe <= strap_valid && ee_active && ctrl[`HSC_CTRL_EE_DOE]; // R7
      eeprom_serial_io_out <= ee_active && ctrl[`HSC_CTRL_EE_DOUT]; // R7
      eeprom_pulldown_en <= strap_valid && ee_active; // R6 R7
    end
  end

  // ----------------------------------------------------------------------------
  // strap pin pulls
  // ----------------------------------------------------------------------------
  // pulls follow the synchronised level, so they settle three edges after the pin
  always @(posedge clk) begin
    if (!rst_n) begin
      ind_pulldown_en <= 1'b1;
      oc3_pullup_en <= 1'b0;
    end else begin
      ind_pulldown_en <= ~ind_n_s; // R14
      oc3_pullup_en <= np3_n_s; // R13
    end
  end

  // ----------------------------------------------------------------------------
  // hub descriptor fields
  // ----------------------------------------------------------------------------
  reg [1:0] next_pwr_mode;
  reg [1:0] next_oc_mode;
  reg [7:0] next_pwrgood;
  always @* begin
    next_pwr_mode = ganged ? `HSC_MODE_GANGED : `HSC_MODE_PER_PORT;
    next_oc_mode = ganged ? `HSC_MODE_GANGED : `HSC_MODE_PER_PORT;
    next_pwrgood = `HSC_PWRGOOD_SWITCHED;
    if (bus_powered) begin
      // power switching is always claimed here; protection depends on the pin
      if (ind_n_s) begin
        next_oc_mode = `HSC_MODE_NONE; // R16
      end
    end else begin
      // protection always claimed; switching and its delay depend on the pin
      if (ind_n_s) begin
        next_pwr_mode = `HSC_MODE_NONE;
        next_pwrgood = `HSC_PWRGOOD_NONE; // R18
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      hub_characteristics <= 8'h00;
      port_power_on_n_to_pwrgood <= 8'h00;
    end else if (strap_valid) begin
      hub_characteristics <= {3'h0, next_oc_mode, 1'b0, next_pwr_mode}; // R15 R16 R17
      port_power_on_n_to_pwrgood <= next_pwrgood; // R18
    end
  end

  // ----------------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------------
  // one wait state: pready rises one edge into the access phase, which keeps
  // prdata a flop output at the cost of one cycle per transfer
  wire access;
  wire commit;
  wire hit_ctrl;
  wire hit_status;
  wire hit_desc;
  assign access = psel && penable && !pready;
  assign commit = psel && penable && pready;
  assign hit_ctrl = (paddr == `HSC_OFF_CTRL);
  assign hit_status = (paddr == `HSC_OFF_STATUS);
  assign hit_desc = (paddr == `HSC_OFF_DESC);

  reg [31:0] status_word;
  always @* begin
    status_word = 32'h00000000;
    status_word[`HSC_ST_BUS_POWERED] = bus_powered;
    status_word[`HSC_ST_EE_ACTIVE] = ee_active;
    status_word[`HSC_ST_GANGED] = ganged;
    status_word[`HSC_ST_IND_PIN] = ind_n_s;
    status_word[`HSC_ST_PULLUP] = upstream_pullup_enable;
    status_word[`HSC_ST_TWO_PORT] = np3_n_s;
    status_word[`HSC_ST_OC_LSB +: 3] = oc_active;
    status_word[`HSC_ST_EE_DIN] = shared_s;
    status_word[`HSC_ST_PWR_LSB +: 3] = ~port_power_on_n;
  end

  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `HSC_OFF_CTRL: begin
        next_rdata = ctrl;
      end
      `HSC_OFF_STATUS: begin
        next_rdata = status_word;
      end
      `HSC_OFF_DESC: begin
        next_rdata = {16'h0000, port_power_on_n_to_pwrgood, hub_characteristics};
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access && !(hit_ctrl || hit_status || hit_desc);
      prdata <= (access && !pwrite) ? next_rdata : 32'h00000000;
    end
  end

  // only the defined control bits are kept; the rest read back as zero
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= `HSC_CTRL_RESET;
    end else if (commit && pwrite && hit_ctrl) begin
      ctrl <= pwdata & 32'h000000F7;
    end
  end

endmodule

// ===== rtl/hsc_map.vh
// hsc_map.vh: constants for the hub strap, descriptor and pull-up timing block.
// assumes a 100 MHz core clock; included by bare name, definitions only.
`ifndef HSC_MAP_VH
`define HSC_MAP_VH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define HSC_CLK_PERIOD_NS 10
`define HSC_PUR_TIME_NS 3000000
// 3 ms of 10 ns cycles, sized to the timer width
`define HSC_PUR_CYCLES 19'h493E0
`define HSC_PUR_CNT_W 19
`define HSC_OC_FILT_NS 1000
`define HSC_OC_FILT_CYCLES (`HSC_OC_FILT_NS / `HSC_CLK_PERIOD_NS)
`define HSC_OC_FILT_LAST 7'h63
`define HSC_OC_CNT_W 7

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define HSC_ADDR_W 8
`define HSC_OFF_CTRL 8'h00
`define HSC_OFF_STATUS 8'h04
`define HSC_OFF_DESC 8'h08

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define HSC_CTRL_PWR_REQ_LSB 0
`define HSC_CTRL_EE_CLK 4
`define HSC_CTRL_EE_DOUT 5
`define HSC_CTRL_EE_DOE 6
`define HSC_CTRL_GANG_SW 7
`define HSC_CTRL_RESET 32'h00000000

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define HSC_ST_BUS_POWERED 0
`define HSC_ST_EE_ACTIVE 1
`define HSC_ST_GANGED 2
`define HSC_ST_IND_PIN 3
`define HSC_ST_PULLUP 4
`define HSC_ST_TWO_PORT 5
`define HSC_ST_OC_LSB 8
`define HSC_ST_EE_DIN 11
`define HSC_ST_PWR_LSB 12

// ----------------------------------------------------------------------------
// hub descriptor encodings
// ----------------------------------------------------------------------------
`define HSC_MODE_GANGED 2'h0
`define HSC_MODE_PER_PORT 2'h1
`define HSC_MODE_NONE 2'h2
`define HSC_PWRGOOD_SWITCHED 8'h32
`define HSC_PWRGOOD_NONE 8'h00

`endif

// ===== rtl/hsc_oc_filter.v
// hsc_oc_filter.v: glitch filter for one active-low overcurrent input.
// assumes the input is already synchronous to clk.
`timescale 1ns/1ps
`include "hsc_map.vh"

module hsc_oc_filter (
  input wire clk,
  input wire rst_n,
  input wire raw_n,
  output reg filt_n
);

  reg [`HSC_OC_CNT_W-1:0] stable_cnt;

  // ----------------------------------------------------------------------------
  // accept a new level only after it has held for the whole filter window
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      stable_cnt <= {`HSC_OC_CNT_W{1'b0}};
      filt_n <= 1'b1;
    end else if (raw_n == filt_n) begin
      stable_cnt <= {`HSC_OC_CNT_W{1'b0}};
    end else if (stable_cnt == `HSC_OC_FILT_LAST) begin
      stable_cnt <= {`HSC_OC_CNT_W{1'b0}};
      filt_n <= raw_n;
    end else begin
      stable_cnt <= stable_cnt + 1'b1;
    end
  end

endmodule

// ===== rtl/hsc_pullup_timer.v
// hsc_pullup_timer.v: delay counter that holds the upstream pull-up off.
// assumes restart is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`include "hsc_map.vh"

module hsc_pullup_timer #(
  parameter [`HSC_PUR_CNT_W-1:0] CYCLES = `HSC_PUR_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire restart,
  output reg done
);

  reg [`HSC_PUR_CNT_W-1:0] count;

  // ----------------------------------------------------------------------------
  // count from zero; a restart while running starts over
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n || restart) begin
      count <= {`HSC_PUR_CNT_W{1'b0}};
      done <= 1'b0;
    end else if (!done) begin
      if (count == CYCLES - 1'b1) begin
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// ===== tb/hsc_assertions.sv
// hsc_assertions.sv: pin-level timing and strap checks for hsc_top.
// assumes one clock, synchronous active-low reset, straps held across reset.
`timescale 1ns/1ps
module hsc_assertions #(
  parameter int PUR_CYCLES = 300000
) (
  input wire clk,
  input wire rst_n,
  input wire power_source_select_n,
  input wire eeprom_enable_n,
  input wire three_port_n,
  input wire overcurrent_protect_ind_n,
  input wire [2:0] port_overcurrent_n,
  input wire eeprom_serial_io_in,
  input wire eeprom_serial_io_oe,
  input wire eeprom_serial_clock_oe,
  input wire eeprom_pulldown_en,
  input wire ind_pulldown_en,
  input wire oc3_pullup_en,
  input wire upstream_pullup_enable,
  input wire [2:0] port_power_on_n,
  input wire [7:0] hub_characteristics,
  input wire [7:0] port_power_on_n_to_pwrgood
);
  // ----
  // helper counters
  // ----
  logic [19:0] low_cnt;
  logic [3:0] since_chg;
  logic [7:0] oc_cnt;
  logic ps_q;
  always_ff @(posedge clk) begin
    ps_q <= power_source_select_n;
    if (!rst_n) begin
      low_cnt <= 20'h00000;
      since_chg <= 4'hF;
      oc_cnt <= 8'h00;
    end else begin
      low_cnt <= upstream_pullup_enable ? 20'h00000 : low_cnt + 20'h00001;
      since_chg <= (power_source_select_n != ps_q) ? 4'h0 : since_chg + {3'h0, since_chg != 4'hF};
      oc_cnt <= port_overcurrent_n[0] ? 8'h00 : oc_cnt + {7'h00, oc_cnt != 8'hFF};
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // margins of a few cycles cover the two-flop strap synchroniser
  sequence steady_s;
    ($stable(power_source_select_n) && $stable(overcurrent_protect_ind_n))[*8];
  endsequence
  sequence gang_s;
    (eeprom_enable_n && !eeprom_serial_io_in)[*8];
  endsequence
  pullup_drop_a: assert property ($changed(power_source_select_n) |-> ##[1:5] !upstream_pullup_enable)
    else $error("pull-up still on after power select change");
  pullup_delay_a: assert property ($rose(upstream_pullup_enable) |-> low_cnt >= PUR_CYCLES)
    else $error("pull-up rose before the delay ran out");
  pullup_hold_a: assert property ($fell(upstream_pullup_enable) |-> since_chg <= 4'h5)
    else $error("pull-up dropped without a trigger");
  ee_idle_a: assert property (eeprom_enable_n[*6] |-> !eeprom_serial_clock_oe && !eeprom_serial_io_oe)
    else $error("eeprom pins driven while interface disabled");
  ee_pull_a: assert property ((!eeprom_enable_n)[*6] |-> eeprom_pulldown_en)
    else $error("eeprom pulldowns off while interface active");
  ind_pull_a: assert property (overcurrent_protect_ind_n[*6] |-> !ind_pulldown_en)
    else $error("indication pulldown on while pin high");
  oc3_pull_a: assert property (three_port_n[*6] |-> oc3_pullup_en)
    else $error("third overcurrent pull-up off in two-port mode");
  gang_ports_a: assert property (gang_s |-> port_power_on_n == 3'h0 || port_power_on_n == 3'h7)
    else $error("ganged port power outputs differ");
  pwrgood_a: assert property (steady_s |->
    port_power_on_n_to_pwrgood == ((power_source_select_n && overcurrent_protect_ind_n) ? 8'h00 : 8'h32))
    else $error("power-good time wrong for strap setting");
  d4_mode_a: assert property (steady_s ##0 !power_source_select_n |->
    hub_characteristics[4] == overcurrent_protect_ind_n)
    else $error("characteristics bit 4 does not follow indication pin");
  oc_off_a: assert property (oc_cnt >= 8'h6A |-> port_power_on_n[0])
    else $error("port one powered during held overcurrent");
endmodule

bind hsc_top hsc_assertions #(.PUR_CYCLES(PUR_CYCLES)) u_chk (
  .clk, .rst_n, .power_source_select_n, .eeprom_enable_n, .three_port_n,
  .overcurrent_protect_ind_n, .port_overcurrent_n, .eeprom_serial_io_in, .eeprom_serial_io_oe,
  .eeprom_serial_clock_oe, .eeprom_pulldown_en, .ind_pulldown_en, .oc3_pullup_en,
  .upstream_pullup_enable, .port_power_on_n, .hub_characteristics, .port_power_on_n_to_pwrgood
);

// ===== tb/hsc_switch_model.sv
// hsc_switch_model.sv: external port power switches reporting overcurrent.
// assumes fault commands from the bench, changed just after clk edges.
`timescale 1ns/1ps
module hsc_switch_model (
  input wire clk,
  input wire [2:0] fault,
  input wire tie_all,
  output logic [2:0] port_overcurrent_n
);
  initial port_overcurrent_n = 3'h7;
  // flags lag the fault by one edge, like a sense path
  always @(posedge clk) begin
    if (tie_all) begin
      port_overcurrent_n <= {3{~|fault}};
    end else begin
      port_overcurrent_n <= ~fault;
    end
  end
endmodule

// ===== tb/hub_strap_config_and_descriptor_tb.sv
// hub_strap_config_and_descriptor_tb.sv: directed tests of straps, descriptor, port power, pull-up.
// assumes hsc_top with a short pull-up delay and the switch model on the overcurrent pins.
`timescale 1ns/1ps
`include "hsc_map.vh"
module hub_strap_config_and_descriptor_tb;
  localparam logic [18:0] PUR = 19'h00014;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic power_source_select_n = 1'b0, eeprom_enable_n = 1'b1, three_port_n = 1'b1;
  logic overcurrent_protect_ind_n = 1'b0, gang_lvl = 1'b1, tie_all = 1'b0;
  logic [2:0] fault = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, eeprom_serial_io_out, eeprom_serial_io_oe, eeprom_serial_clock_out;
  wire eeprom_serial_clock_oe, eeprom_pulldown_en, ind_pulldown_en, oc3_pullup_en, upstream_pullup_enable;
  wire [2:0] port_overcurrent_n, port_power_on_n;
  wire [7:0] hub_characteristics, port_power_on_n_to_pwrgood;
  wire eeprom_serial_io_in;
  int miscompares = 0;
  int n_tests = 0;
  // shared pin: device drive, else pulldown in eeprom mode, else board strap
  assign eeprom_serial_io_in = (eeprom_serial_io_oe === 1'b1) ? eeprom_serial_io_out :
                               (eeprom_pulldown_en === 1'b1) ? 1'b0 : gang_lvl;
  always #5 clk = ~clk;
  hsc_top #(.PUR_CYCLES(PUR)) DUT (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_source_select_n, .eeprom_enable_n, .three_port_n, .overcurrent_protect_ind_n,
    .port_overcurrent_n, .eeprom_serial_io_in, .eeprom_serial_io_out, .eeprom_serial_io_oe,
    .eeprom_serial_clock_out, .eeprom_serial_clock_oe, .eeprom_pulldown_en, .ind_pulldown_en,
    .oc3_pullup_en, .upstream_pullup_enable, .port_power_on_n, .hub_characteristics, .port_power_on_n_to_pwrgood
  );
  hsc_switch_model u_sw (.clk, .fault, .tie_all, .port_overcurrent_n);
  // ----
  // tasks
  // ----
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task print_verdict;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end
  initial begin
    tick(6);
    rst_n <= 1'b1;
    tick(10);
    chk(upstream_pullup_enable, 1'h0);
    tick(PUR);
    chk(upstream_pullup_enable, 1'h1);
    apb(1'b0, `HSC_OFF_STATUS, 32'h0);
    chk(q & 32'h27, 32'h21);
    apb(1'b0, `HSC_OFF_DESC, 32'h0);
    chk(q & 32'hFF1B, 32'h3209);
    chk({oc3_pullup_en, ind_pulldown_en, eeprom_serial_clock_oe}, 3'h6);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, q[7:0]}, 9'h100);
    apb(1'b1, `HSC_OFF_CTRL, 32'h7);
    tick(4);
    chk(port_power_on_n, 3'h0);
    fault <= 3'h1;
    tick(20);
    fault <= 3'h0;
    tick(110);
    chk(port_power_on_n, 3'h0);
    fault <= 3'h1;
    tick(30);
    chk(port_power_on_n, 3'h0);
    fault <= 3'h1;
    tick(110);
    chk(port_power_on_n, 3'h1);
    fault <= 3'h0;
    tick(110);
    chk(port_power_on_n, 3'h0);
    fault <= 3'h4;
    tick(110);
    chk(port_power_on_n, 3'h0);
    three_port_n <= 1'b0;
    tick(4);
    chk(port_power_on_n, 3'h4);
    three_port_n <= 1'b1;
    fault <= 3'h0;
    gang_lvl <= 1'b0;
    tie_all <= 1'b1;
    tick(8);
    apb(1'b0, `HSC_OFF_DESC, 32'h0);
    chk(q & 32'hFF1B, 32'h3200);
    fault <= 3'h2;
    tick(110);
    chk(port_power_on_n, 3'h7);
    fault <= 3'h0;
    tick(110);
    chk(port_power_on_n, 3'h0);
    overcurrent_protect_ind_n <= 1'b1;
    tick(8);
    chk({ind_pulldown_en, port_power_on_n_to_pwrgood, hub_characteristics & 8'h1B}, 17'h03210);
    gang_lvl <= 1'b1;
    power_source_select_n <= 1'b1;
    tick(12);
    power_source_select_n <= 1'b0;
    tick(18);
    chk(upstream_pullup_enable, 1'h0);
    power_source_select_n <= 1'b1;
    tick(30);
    chk(upstream_pullup_enable, 1'h1);
    chk({port_power_on_n_to_pwrgood, hub_characteristics & 8'h18}, 16'h0008);
    overcurrent_protect_ind_n <= 1'b0;
    tick(8);
    chk(port_power_on_n_to_pwrgood, 8'h32);
    eeprom_enable_n <= 1'b0;
    tick(8);
    chk(eeprom_pulldown_en, 1'h1);
    apb(1'b1, `HSC_OFF_CTRL, 32'h70);
    tick(2);
    chk({eeprom_serial_clock_out, eeprom_serial_clock_oe, eeprom_serial_io_out, eeprom_serial_io_oe}, 4'hF);
    tick(4);
    apb(1'b0, `HSC_OFF_STATUS, 32'h0);
    chk(q & 32'h802, 32'h802);
    eeprom_enable_n <= 1'b1;
    tick(8);
    chk({eeprom_serial_clock_oe, eeprom_serial_io_oe}, 2'h0);
    print_verdict;
  end
endmodule
